// ### eeid_ecc.sv
// Single-error-correcting code over one four-byte group.
// Pure combinational; the caller stores data and check bits side by side.
`timescale 1ns/1ps

module eeid_ecc (
   // Stored group being read
   input  wire logic [31:0] raw_data_in,
   input  wire logic [5:0]  raw_check_in,
   output logic [31:0]      fixed_data_out,
   // Group about to be written
   input  wire logic [31:0] wr_data_in,
   output logic [5:0]       wr_check_out
);

   // Hamming positions 1..38, powers of two hold check bits
   always_comb begin
      logic [5:0] syn;
      logic [5:0] code;
      int         k;
      syn            = raw_check_in;
      code           = 6'h0;
      k              = 0;
      fixed_data_out = raw_data_in;
      for (int p = 1; p < 39; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (raw_data_in[k]) begin
               syn = syn ^ 6'(p);
            end
            if (wr_data_in[k]) begin
               code = code ^ 6'(p);
            end
            k++;
         end
      end
      // A syndrome on a check position needs no data fix
      k = 0;
      for (int p = 1; p < 39; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (syn == 6'(p)) begin
               fixed_data_out[k] = ~raw_data_in[k];
            end
            k++;
         end
      end
      wr_check_out = code;
   end

endmodule

// ### eeid_pkg.sv
// Types shared by the identification-page lock block.
// Assumes eeid_regs.svh sits in the include path.
`include "eeid_regs.svh"

package eeid_pkg;

   // Serial protocol phase
   typedef enum logic [2:0] {
      SPI_IDLE,
      SPI_CMD,
      SPI_ADDR,
      SPI_DIN,
      SPI_DOUT,
      SPI_SKIP
   } eeid_spi_e;

   // One ECC group: check bits [37:32], stored data [31:0]
   typedef logic [37:0] eeid_group_t;

   // Whole state of the top module
   typedef struct packed {
      logic [1:0]             cs_s;
      logic [1:0]             sck_s;
      logic [1:0]             si_s;
      logic                   cs_prev;
      logic                   sck_prev;
      eeid_spi_e              st;
      logic [2:0]             bitcnt;
      logic [7:0]             shin;
      logic [7:0]             shout;
      logic                   so;
      logic                   oe_n;
      logic                   cmd_wr;
      logic                   is_lock;
      logic [3:0]             addr;
      logic                   ovf;
      logic                   got_byte;
      logic [7:0]             wdata;
      logic [3:0]             waddr;
      logic                   busy;
      logic [18:0]            timer;
      logic                   wr_lock;
      logic                   write_enable_latch;
      logic                   block_protect_hi;
      logic                   block_protect_lo;
      logic                   locked;
      logic [3:0][37:0]       mem;
      logic                   ack;
      logic [31:0]            rdata;
   } eeid_state_s;

endpackage

// ### eeid_regs.svh
// Constants for the identification-page lock block: register offsets,
// field positions, reset values, opcodes and timing values in ns.
// Assumes inclusion from the block package and from the top module.
`ifndef EEID_REGS_SVH
`define EEID_REGS_SVH

// Clock period and write cycle time, both in ns
`define EEID_CLK_NS        8
`define EEID_TWC_NS        4000000

// Register byte offsets
`define EEID_REG_CTRL      4'h0
`define EEID_REG_STAT      4'h4

// Control fields and reset value
`define EEID_CTRL_BP_LO    0
`define EEID_CTRL_BP_HI    1
`define EEID_CTRL_RST      2'h0

// Status fields
`define EEID_STAT_LOCKED   0
`define EEID_STAT_WR_EN    1
`define EEID_STAT_BUSY     2

// Opcodes, bit 3 is a don't care
`define EEID_OPC_MASK      8'hF7
`define EEID_OPC_WR_ENABLE 8'h06
`define EEID_OPC_IDRD      8'h83
`define EEID_OPC_IDWR      8'h82

// Address and data fields
`define EEID_ADDR_LOCKSEL  7
`define EEID_LOCK_DATA_BIT 1
`define EEID_ID_LAST       4'hF
`define EEID_ERASED_BYTE   8'hFF
`define EEID_BP_ALL        2'h3

`endif

// ### eeid_spi_host.sv
// SPI mode 0 host model that drives the serial pins of the block.
// Assumes clk_in is the block clock; SCK half period is five clocks (80 ns SCK).
`timescale 1ns/1ps

module eeid_spi_host (
   // Block clock
   input  wire logic clk_in,
   // Serial pins
   input  wire logic so_in,
   input  wire logic so_oe_n_in,
   output logic      cs_n_out,
   output logic      sck_out,
   output logic      si_out
);
   logic so_last;
   logic so_wire;

   // Released SO shows the inverse of its last level, so a stale bit never matches
   assign so_wire = so_oe_n_in ? ~so_last : so_in;

   // Idle pins at time zero: deselected, SCK parked low
   initial begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      si_out = 1'b0;
      so_last = 1'b0;
   end

   // Wait a number of block clocks
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Select the device, then give CS setup before the first SCK rise
   task automatic start();
      tick(1);
      cs_n_out <= 1'b0;
      tick(5);
   endtask

   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx, output logic drv);
      drv = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         si_out <= tx[i];
         tick(5);
         rx[i] = so_wire;
         if (so_oe_n_in === 1'b0) begin
            drv = 1'b1;
            so_last = so_in;
         end
         sck_out <= 1'b1;
         tick(5);
         sck_out <= 1'b0;
      end
   endtask

   // CS rise before next SCK rise
   task automatic stop();
      tick(2);
      cs_n_out <= 1'b1;
      si_out <= ~si_out;
      tick(6);
   endtask
endmodule

// ### eeid_top.sv
// Identification page, its lock and the serial slave that reaches them.
// Assumes an SPI mode 0 host much slower than clk_in and an Avalon-MM master.
`timescale 1ns/1ps
`include "eeid_regs.svh"

module eeid_top #(
   parameter int WRITE_CYCLES = `EEID_TWC_NS / `EEID_CLK_NS
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   // Serial pins, asynchronous to clk_in
   input  wire logic        cs_n_in,
   input  wire logic        sck_in,
   input  wire logic        si_in,
   output logic             so_out,
   output logic             so_oe_n_out,
   // Avalon-MM register slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);

   localparam logic [18:0] WR_LAST = 19'(WRITE_CYCLES - 1);

   // Nonvolatile cells start cleared, i.e. erased, unlocked
   eeid_pkg::eeid_state_s s = '0;
   eeid_pkg::eeid_state_s n;

   logic        sck_rise;
   logic        sck_fall;
   logic        cs_rise;
   logic        cs_low;
   logic [7:0]  new_byte;
   logic [3:0]  next_addr;
   logic [3:0]  rd_addr;
   logic [1:0]  grp_sel;
   logic [31:0] grp_fixed;
   logic [31:0] wr_word;
   logic [5:0]  wr_chk;
   logic [7:0]  rd_byte;
   logic [1:0]  bp;
   logic        bus_req;
   logic        lock_ok;
   logic        idwr_ok;

   // Edges seen after the second sync stage only
   assign sck_rise  = s.sck_s[1] & ~s.sck_prev;
   assign sck_fall  = ~s.sck_s[1] & s.sck_prev;
   assign cs_rise   = s.cs_s[1] & ~s.cs_prev;
   assign cs_low    = ~s.cs_s[1];
   assign new_byte  = {s.shin[6:0], s.si_s[1]};
   assign next_addr = s.addr + 4'h1;
   assign bp        = {s.block_protect_hi, s.block_protect_lo};
   assign bus_req   = avs_read | avs_write;

   // One decoder serves reads and the group rewrite; a busy cycle owns it
   always_comb begin
      if (s.busy) begin
         rd_addr = s.waddr;
      end else if (s.st == eeid_pkg::SPI_ADDR) begin
         rd_addr = new_byte[3:0];
      end else begin
         rd_addr = next_addr;
      end
   end
   assign grp_sel = rd_addr[3:2];

   // Stored image is inverted so cleared cells read as all ones
   // erased reads ones
   assign rd_byte = ~grp_fixed[{rd_addr[1:0], 3'h0} +: 8];

   always_comb begin
      wr_word = grp_fixed;
      wr_word[{s.waddr[1:0], 3'h0} +: 8] = ~s.wdata;
   end

   eeid_ecc u_ecc (
      .raw_data_in    (s.mem[grp_sel][31:0]),
      .raw_check_in   (s.mem[grp_sel][37:32]),
      .fixed_data_out (grp_fixed),
      .wr_data_in     (wr_word),
      .wr_check_out   (wr_chk)
   );

   // Acceptance checks taken at the CS rise that closes a write frame
   // write enable required
   assign lock_ok = s.write_enable_latch && (bp != `EEID_BP_ALL) && !s.locked
                    && s.wdata[`EEID_LOCK_DATA_BIT] && !s.ovf;
   assign idwr_ok = s.write_enable_latch && !s.locked;

   // Next-state logic for the whole block
   always_comb begin
      n          = s;
      n.cs_s     = {s.cs_s[0], cs_n_in};
      n.sck_s    = {s.sck_s[0], sck_in};
      n.si_s     = {s.si_s[0], si_in};
      n.cs_prev  = s.cs_s[1];
      n.sck_prev = s.sck_s[1];

      // Self-timed write cycle
      if (s.busy) begin
         if (s.timer == WR_LAST) begin
            n.busy = 1'h0;
            n.write_enable_latch = 1'h0;
            if (s.wr_lock) begin
               n.locked = 1'h1;
            end else begin
               n.mem[s.waddr[3:2]] = {wr_chk, wr_word};
            end
         end else begin
            n.timer = s.timer + 19'h1;
         end
      end

      // Serial protocol
      if (!cs_low) begin
         n.st     = eeid_pkg::SPI_IDLE;
         n.oe_n   = 1'h1;
         n.bitcnt = 3'h0;
         if (cs_rise && s.st == eeid_pkg::SPI_DIN && s.got_byte && s.bitcnt == 3'h0 && !s.busy) begin
            if (s.is_lock ? lock_ok : idwr_ok) begin
               n.busy    = 1'h1;
               n.timer   = 19'h0;
               n.wr_lock = s.is_lock;
            end
         end
      end else begin
         case (s.st)
            eeid_pkg::SPI_IDLE: begin
               n.st     = eeid_pkg::SPI_CMD;
               n.bitcnt = 3'h0;
            end
            eeid_pkg::SPI_CMD: begin
               if (sck_rise) begin
                  n.shin   = new_byte;
                  n.bitcnt = s.bitcnt + 3'h1;
                  if (s.bitcnt == 3'h7) begin
                     n.st = eeid_pkg::SPI_SKIP;
                     if (!s.busy) begin
                        if ((new_byte & `EEID_OPC_MASK) == `EEID_OPC_WR_ENABLE) begin
                           n.write_enable_latch = 1'h1;
                        end else if ((new_byte & `EEID_OPC_MASK) == `EEID_OPC_IDRD) begin
                           n.cmd_wr = 1'h0;
                           n.st     = eeid_pkg::SPI_ADDR;
                        end else if ((new_byte & `EEID_OPC_MASK) == `EEID_OPC_IDWR) begin
                           n.cmd_wr = 1'h1;
                           n.st     = eeid_pkg::SPI_ADDR;
                        end
                     end
                  end
               end
            end
            eeid_pkg::SPI_ADDR: begin
               if (sck_rise) begin
                  n.shin   = new_byte;
                  n.bitcnt = s.bitcnt + 3'h1;
                  if (s.bitcnt == 3'h7) begin
                     n.is_lock = new_byte[`EEID_ADDR_LOCKSEL];
                     n.addr    = new_byte[3:0];
                     n.ovf     = 1'h0;
                     if (s.cmd_wr) begin
                        n.st       = eeid_pkg::SPI_DIN;
                        n.got_byte = 1'h0;
                     end else begin
                        n.st   = eeid_pkg::SPI_DOUT;
                        n.oe_n = 1'h0;
                        if (new_byte[`EEID_ADDR_LOCKSEL]) begin
                           n.shout = {7'h0, s.locked};
                        end else begin
                           n.shout = rd_byte;
                        end
                     end
                  end
               end
            end
            eeid_pkg::SPI_DIN: begin
               if (sck_rise) begin
                  // any clock past the first data byte spoils a lock
                  if (s.got_byte) begin
                     n.ovf = 1'h1;
                  end
                  n.shin   = new_byte;
                  n.bitcnt = s.bitcnt + 3'h1;
                  if (s.bitcnt == 3'h7) begin
                     // Only the last byte of a page write is kept
                     n.got_byte = 1'h1;
                     n.wdata    = new_byte;
                     n.waddr    = s.addr;
                     n.addr     = next_addr;
                  end
               end
            end
            eeid_pkg::SPI_DOUT: begin
               // Mode 0: change SO on the falling edge
               if (sck_fall) begin
                  n.so     = s.shout[7];
                  n.shout  = {s.shout[6:0], 1'h0};
                  n.bitcnt = s.bitcnt + 3'h1;
                  if (s.bitcnt == 3'h7) begin
                     if (s.is_lock) begin
                        n.shout = {7'h0, s.locked};
                     end else if (s.ovf || s.addr == `EEID_ID_LAST) begin
                        n.ovf   = 1'h1;
                        n.shout = `EEID_ERASED_BYTE;
                     end else begin
                        n.addr  = next_addr;
                        n.shout = rd_byte;
                     end
                  end
               end
            end
            default: begin
               n.st = eeid_pkg::SPI_SKIP;
            end
         endcase
      end

      // Avalon slave: one wait state, write lands when waitrequest is low
      n.ack = bus_req & ~s.ack;
      if (avs_read && !s.ack) begin
         if (avs_address == `EEID_REG_CTRL) begin
            n.rdata = {30'h0, bp};
         end else if (avs_address == `EEID_REG_STAT) begin
            n.rdata = {29'h0, s.busy, s.write_enable_latch, s.locked};
         end else begin
            n.rdata = 32'h0000_0000;
         end
      end
      if (avs_write && s.ack && avs_address == `EEID_REG_CTRL && avs_byteenable[0]) begin
         n.block_protect_lo = avs_writedata[`EEID_CTRL_BP_LO];
         n.block_protect_hi = avs_writedata[`EEID_CTRL_BP_HI];
      end

      if (srst_in) begin
         n                  = '0;
         n.cs_s             = 2'h3;
         n.cs_prev          = 1'h1;
         n.oe_n             = 1'h1;
         n.st               = eeid_pkg::SPI_IDLE;
         n.block_protect_lo = 1'(`EEID_CTRL_RST);
         n.block_protect_hi = 1'h0;
         n.locked           = s.locked;
         n.mem              = s.mem;
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      s <= n;
   end

   // Outputs from state flops, except waitrequest, which is also gated by the live bus request
   assign so_out          = s.so;
   assign so_oe_n_out     = s.oe_n;
   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = bus_req & ~s.ack;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   sequence sq_wr_start;
      $rose(s.busy);
   endsequence

   sequence sq_wr_end;
      $fell(s.busy);
   endsequence

   a_busy_min_len: assert property (sq_wr_start |=> s.busy [*8])
      else $error("write cycle ended too early");

   a_wel_cleared: assert property (sq_wr_end |-> !s.write_enable_latch)
      else $error("write enable still set after write cycle");

   a_lock_sticky: assert property (s.locked |=> s.locked)
      else $error("lock flag dropped");

   a_lock_cause: assert property ($rose(s.locked) |-> $past(s.busy) && $past(s.wr_lock))
      else $error("lock flag set outside a lock write cycle");

   a_lock_gate_ok: assert property (sq_wr_start and s.wr_lock |-> $past(bp) != 2'h3
         && $past(s.write_enable_latch) && !$past(s.locked))
      else $error("lock cycle started while it should be refused");

   a_mem_frozen: assert property (s.locked && !s.busy |=> $stable(s.mem))
      else $error("identification page changed after lock");

   a_read_not_busy: assert property (s.st == eeid_pkg::SPI_DOUT |-> !s.busy)
      else $error("page output while a write cycle runs");

   a_so_on_fall: assert property ($changed(s.so) |-> $past(sck_fall))
      else $error("SO changed away from a falling clock edge");

   a_deselect_hiz: assert property (!cs_low |=> s.oe_n)
      else $error("SO still driven after deselect");

   a_bus_one_wait: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held longer than one cycle");

endmodule

// ### eeid_top_tb.sv
// Self-checking bench for the identification-page lock block.
// Assumes a short write cycle parameter and the SPI host model beside it.
`timescale 1ns/1ps

module eeid_top_tb;
   localparam int WC = 1000;
   logic        clk_in, srst_in, cs_n, sck, si, so, so_oe_n;
   logic [3:0]  avs_address;
   logic        avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [7:0]  rxb [0:19];
   logic        drv_any;
   int          num_errors = 0;
   int          n_checks = 0;

   eeid_top #(.WRITE_CYCLES(WC)) dut (
      .clk_in(clk_in), .srst_in(srst_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
      .so_out(so), .so_oe_n_out(so_oe_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   eeid_spi_host host (.clk_in(clk_in), .so_in(so), .so_oe_n_in(so_oe_n),
      .cs_n_out(cs_n), .sck_out(sck), .si_out(si));

   // 125 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One Avalon transfer; held until waitrequest is seen low at a rising edge
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_in);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      // Values read here are those the design showed at this rising edge
      do begin
         @(posedge clk_in);
      end while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic stat(input logic [31:0] exp);
      av(1'b0, 4'h4, 32'h0, q);
      chk(q, exp);
   endtask

   // Whole SPI frame: opcode, address, then data bytes; bytes after address land in rxb
   task automatic frame(input logic [7:0] op, ad, dt, input int nb);
      logic [7:0] r;
      logic dv;
      drv_any = 1'b0;
      host.start();
      for (int i = 0; i < nb; i++) begin
         host.xbyte(i == 0 ? op : (i == 1 ? ad : dt), r, dv);
         if (i >= 2) rxb[i-2] = r;
         drv_any |= dv;
      end
      host.stop();
   endtask

   task automatic wr_enable();
      frame(8'h06, 8'h00, 8'h00, 1);
   endtask

   // Poll busy until it drops; only the watchdog ends a hang
   task automatic wait_idle();
      do begin
         av(1'b0, 4'h4, 32'h0, q);
      end while (q[2] !== 1'b0);
   endtask

   task automatic do_reset();
      @(posedge clk_in);
      srst_in <= 1'b1;
      repeat (16) @(posedge clk_in);
      srst_in <= 1'b0;
      repeat (6) @(posedge clk_in);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic t_reset();
      chk({31'h0, so_oe_n}, 32'h1);
      stat(32'h0);
      av(1'b0, 4'h8, 32'h0, q);
      chk(q, 32'h0);
      $display("t_reset done");
   endtask

   // Erased page, increment and no wrap past the last byte
   task automatic t_blank();
      frame(8'h83, 8'h00, 8'h00, 21);
      chk({31'h0, drv_any}, 32'h1);
      for (int i = 0; i < 16; i++) chk({24'h0, rxb[i]}, 32'h0000_00FF);
      for (int i = 16; i < 19; i++) chk({24'h0, rxb[i]}, 32'h0000_00FF);
      $display("t_blank done");
   endtask

   // Status byte with the don't care opcode bit set, repeated
   task automatic t_lsr();
      frame(8'h8B, 8'hFF, 8'h00, 4);
      chk({31'h0, drv_any}, 32'h1);
      for (int i = 0; i < 2; i++) chk({24'h0, rxb[i]}, 32'h0000_0000);
      $display("t_lsr done");
   endtask

   // Single byte write inside a group, neighbours untouched; a wrap would bring it back
   task automatic t_write();
      wr_enable();
      frame(8'h82, 8'h01, 8'hA5, 3);
      stat(32'h6);
      wait_idle();
      stat(32'h0);
      frame(8'h83, 8'h00, 8'h00, 6);
      chk({rxb[0], rxb[1], rxb[2], rxb[3]}, 32'hFFA5_FFFF);
      frame(8'h83, 8'h0F, 8'h00, 5);
      chk({8'h0, rxb[0], rxb[1], rxb[2]}, 32'h00FF_FFFF);
      $display("t_write done");
   endtask

   // Every refusal leaves the device neither busy nor locked
   task automatic t_refuse();
      frame(8'h82, 8'h80, 8'h02, 3);
      stat(32'h0);
      wr_enable();
      frame(8'h82, 8'h80, 8'hFD, 3);
      av(1'b0, 4'h4, 32'h0, q);
      chk(q & 32'h5, 32'h0);
      av(1'b1, 4'h0, 32'h3, q);
      av(1'b0, 4'h0, 32'h0, q);
      chk(q, 32'h3);
      wr_enable();
      frame(8'h82, 8'h80, 8'h02, 3);
      av(1'b0, 4'h4, 32'h0, q);
      chk(q & 32'h5, 32'h0);
      av(1'b1, 4'h0, 32'h0, q);
      wr_enable();
      frame(8'h82, 8'h80, 8'h02, 4);
      av(1'b0, 4'h4, 32'h0, q);
      chk(q & 32'h5, 32'h0);
      $display("t_refuse done");
   endtask

   // Valid lock, commands ignored while busy, then read-only page
   task automatic t_lock();
      wr_enable();
      frame(8'h82, 8'hC0, 8'hFF, 3);
      stat(32'h6);
      frame(8'h83, 8'h80, 8'h00, 3);
      chk({31'h0, drv_any}, 32'h0);
      frame(8'h83, 8'h05, 8'h00, 3);
      chk({31'h0, drv_any}, 32'h0);
      wait_idle();
      stat(32'h1);
      frame(8'h83, 8'h80, 8'h00, 3);
      chk({24'h0, rxb[0]}, 32'h0000_0001);
      wr_enable();
      frame(8'h82, 8'h01, 8'h3C, 3);
      wait_idle();
      frame(8'h83, 8'h01, 8'h00, 3);
      chk({24'h0, rxb[0]}, 32'h0000_00A5);
      frame(8'h82, 8'h80, 8'h02, 3);
      stat(32'h3);
      do_reset();
      stat(32'h1);
      $display("t_lock done");
   endtask

   // Stop a hung run
   initial begin
      repeat (60000) @(posedge clk_in);
      num_errors++;
      end_of_test();
   end

   initial begin
      srst_in = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      do_reset();
      t_reset();
      t_blank();
      t_lsr();
      t_write();
      t_refuse();
      t_lock();
      end_of_test();
   end
endmodule
